// ---- rtl/pllw_pkg.sv ----
// package: register map, field layout, timing and shared types of the pll wrapper
package pllw_pkg;

   // apb word indices; byte address is four times the index
   localparam logic [1:0] IDX_STATUS = 2'h0;
   localparam logic [1:0] IDX_CONTROL = 2'h1;
   localparam logic [1:0] IDX_PHASE = 2'h2;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int WIDTH_NEW = 32;
   localparam int WIDTH_OLD = 16;

   // field positions
   localparam int ST_LOCK_BIT = 0;
   localparam int ST_PDONE_BIT = 1;
   localparam int CT_ARESET_BIT = 0;
   localparam int CT_PFD_BIT = 1;
   localparam int PH_SEL_LSB = 0;
   localparam int PH_SEL_W = 9;
   localparam int PH_CMD_LSB = 30;

   // reset values
   localparam logic ST_LOCK_RST = 1'b1;
   localparam logic ST_PDONE_RST = 1'b0;
   localparam logic CT_ARESET_RST = 1'b0;
   localparam logic CT_PFD_RST = 1'b1;

   // phase step commands; other codes do nothing
   localparam logic [1:0] PH_CMD_UP = 2'h1;
   localparam logic [1:0] PH_CMD_DOWN = 2'h2;

   // access modes of an optional pll signal
   localparam logic [1:0] MODE_REG = 2'h0;
   localparam logic [1:0] MODE_EXPORT = 2'h1;
   localparam logic [1:0] MODE_ABSENT = 2'h2;

   // least pll reset pulse, rounded up to whole cycles
   localparam int CLK_PERIOD_NS = 8;
   localparam int PLL_RST_NS = 1000;
   localparam int PLL_RST_CYC = (PLL_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] PLL_RST_LAST = CNT_W'(PLL_RST_CYC - 1);

   typedef enum logic [1:0] {SEQ_PLL_RST, SEQ_WAIT_LOCK, SEQ_RUN} pllw_seq_e;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } pllw_apb_req_s;

   typedef struct packed {
      logic pready;
      logic [DATA_W-1:0] prdata;
      logic pslverr;
   } pllw_apb_rsp_s;

   typedef struct packed {
      logic up;
      logic down;
      logic [PH_SEL_W-1:0] sel;
   } pllw_phase_s;

endpackage

// ---- rtl/pllw_sync.sv ----
// two-flop synchroniser for the pll status levels
`timescale 1ns/10ps
module pllw_sync
   import pllw_pkg::*;
#(
   parameter int W = 2,
   parameter logic [W-1:0] RST_VAL = '0
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] ff1;
      logic [W-1:0] ff2;
   } pllw_sync_s;

   pllw_sync_s s_reg;
   pllw_sync_s s_next;

   // first stage feeds only the second stage
   always_comb
   begin
      s_next = s_reg;
      s_next.ff1 = d;
      s_next.ff2 = s_reg.ff1;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_reg <= {RST_VAL, RST_VAL};
      end
      else if (ce)
      begin
         s_reg <= s_next;
      end
   end

   assign q = s_reg.ff2;

endmodule

// ---- rtl/pllw_ctrl.sv ----
// pll wrapper control: apb registers, reset sequencing and pll control pins
//
// Operation
// - pll and wrapper enter reset automatically at configuration, no software needed.
// - system reset stays asserted until pll reports lock, released only after lock.
// - any pll reset, register or pin, also resets the whole system.
// - pll reset request returns pll to initial settings and resets the system.
// - newer variant: phase detector enable comes only from a control register bit.
// - newer variant: lock, enable and reset request are always top-level ports.
// - software reads lock and triggers pll reset through register bits.
// - each optional pll signal is built as a port, a register bit, or left absent.
// - signals not mapped to a register bit are exported as ports.
// - absent signals default: reset only at configuration, pll and detector enabled.
// - enable input enables the pll; older variant always has it as a port.
// - detector enable high lets pll track; low suspends phase-frequency detection.
// - lock output high only while pll is locked to its reference.
// - pll takes the system clock as reference and makes locked output clocks.
// - older variant: external clock outputs drive only dedicated pins.
// - newer variant: external outputs may also serve as on-chip clocks.
// - status: lock bit 0 resets 1, phase done bit 1 resets 0; read only.
// - control: bit 0 write 1 resets pll; bit 1 resets 1, 0 disables detector.
// - phase register: selector bits 0-8, step bits 30-31; 01 up, 10 down.
// - registers at word offsets 0, 1, 2; 32 bits newer, 16 bits older.
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/10ps
module pllw_ctrl
   import pllw_pkg::*;
#(
   parameter bit NEWER = 1'b1,
   parameter logic [1:0] RST_MODE = MODE_EXPORT,
   parameter logic [1:0] PFD_MODE = MODE_REG,
   parameter bit ENA_PRESENT = 1'b1
)
(
   // clock, configuration reset, clock enable
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // apb slave
   input wire pllw_apb_req_s apb_req,
   output pllw_apb_rsp_s apb_rsp,
   // exported controls from the top level
   input wire logic reset_req_in,
   input wire logic pll_enable_in,
   input wire logic pfd_enable_in,
   // status from the pll macro, asynchronous to clk
   input wire logic pll_locked_raw,
   input wire logic pll_phase_done_raw,
   // pll macro controls
   output logic pll_areset_out,
   output logic pll_ena_out,
   output logic pfd_ena_out,
   output pllw_phase_s phase_out,
   // system side
   output logic sys_rst_n_out,
   output logic lock_out,
   output logic ext_clk_onchip_ok
);

   localparam int RD_W = NEWER ? WIDTH_NEW : WIDTH_OLD;
   localparam logic [DATA_W-1:0] RD_MASK = DATA_W'((64'h1 << RD_W) - 64'h1);
   // newer variant always has the register bit and the pin for reset
   localparam bit RST_REG = NEWER || (RST_MODE == MODE_REG);
   localparam bit RST_PIN = NEWER || (RST_MODE == MODE_EXPORT);
   localparam bit PFD_REG = NEWER || (PFD_MODE == MODE_REG);

   typedef struct packed {
      pllw_seq_e seq;
      logic [CNT_W-1:0] cnt;
      logic areset_bit;
      logic pfd_bit;
      logic [1:0] ph_cmd;
      logic pll_areset;
      logic sys_rst_n;
      logic pll_ena;
      logic pfd_ena;
      logic lock;
      logic ext_ok;
      pllw_phase_s phase;
      pllw_apb_rsp_s rsp;
   } pllw_state_s;

   pllw_state_s s_reg;
   pllw_state_s s_next;
   logic [1:0] stat_sync;
   logic lock_sync;
   logic pdone_sync;
   logic any_rst;
   logic setup;
   logic wr;
   logic [1:0] idx;
   logic mapped;
   logic pfd_sel;

   ////////////////////////////////////////////////////////////////////////////////

   // macro outputs are asynchronous to clk
   pllw_sync #(
      .W(2),
      .RST_VAL({ST_PDONE_RST, ST_LOCK_RST})
   ) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .d({pll_phase_done_raw, pll_locked_raw}),
      .q(stat_sync)
   );

   assign lock_sync = stat_sync[0];
   assign pdone_sync = stat_sync[1];

   ////////////////////////////////////////////////////////////////////////////////

   // bit and pin reach the sequencer when their mode builds them (both in the newer variant); either resets the system
   assign any_rst = (RST_REG && s_reg.areset_bit) || (RST_PIN && reset_req_in);
   assign setup = apb_req.psel && !apb_req.penable;
   assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite && s_reg.rsp.pready;
   assign idx = apb_req.paddr[3:2];
   assign mapped = (apb_req.paddr[1:0] == 2'h0) && (idx != 2'h3);

   // absent enable inputs leave pll and detector enabled
   always_comb
   begin
      if (PFD_REG)
      begin
         pfd_sel = s_reg.pfd_bit;
      end
      else if (PFD_MODE == MODE_EXPORT)
      begin
         pfd_sel = pfd_enable_in;
      end
      else
      begin
         pfd_sel = 1'b1;
      end
   end

   always_comb
   begin
      s_next = s_reg;
      s_next.phase.up = 1'b0;
      s_next.phase.down = 1'b0;

      // registered ready in the access phase gives zero wait states
      s_next.rsp.pready = setup;
      if (setup)
      begin
         s_next.rsp.pslverr = !mapped;
         s_next.rsp.prdata = '0;
         if (mapped)
         begin
            case (idx)
               IDX_STATUS:
               begin
                  s_next.rsp.prdata[ST_LOCK_BIT] = lock_sync;
                  s_next.rsp.prdata[ST_PDONE_BIT] = pdone_sync;
               end
               IDX_CONTROL:
               begin
                  s_next.rsp.prdata[CT_ARESET_BIT] = s_reg.areset_bit;
                  s_next.rsp.prdata[CT_PFD_BIT] = s_reg.pfd_bit;
               end
               IDX_PHASE:
               begin
                  s_next.rsp.prdata[PH_SEL_LSB +: PH_SEL_W] = s_reg.phase.sel;
                  s_next.rsp.prdata[PH_CMD_LSB +: 2] = s_reg.ph_cmd;
               end
               default:
               begin
                  s_next.rsp.prdata = '0;
               end
            endcase
            s_next.rsp.prdata = s_next.rsp.prdata & RD_MASK;
         end
      end

      // writes land at the sampling edge; status writes are dropped
      if (wr && !s_reg.rsp.pslverr)
      begin
         case (idx)
            IDX_CONTROL:
            begin
               s_next.areset_bit = apb_req.pwdata[CT_ARESET_BIT];
               s_next.pfd_bit = apb_req.pwdata[CT_PFD_BIT];
            end
            IDX_PHASE:
            begin
               s_next.phase.sel = apb_req.pwdata[PH_SEL_LSB +: PH_SEL_W];
               s_next.ph_cmd = apb_req.pwdata[PH_CMD_LSB +: 2];
               // stepping exists only in the newer variant
               s_next.phase.up = NEWER
                  && (apb_req.pwdata[PH_CMD_LSB +: 2] == PH_CMD_UP);
               s_next.phase.down = NEWER && (apb_req.pwdata[PH_CMD_LSB +: 2] == PH_CMD_DOWN);
            end
            default:
            begin
               s_next.ph_cmd = s_reg.ph_cmd;
            end
         endcase
      end

      // reset sequencer
      case (s_reg.seq)
         SEQ_PLL_RST:
         begin
            s_next.pll_areset = 1'b1;
            s_next.sys_rst_n = 1'b0;
            if (s_reg.cnt != PLL_RST_LAST)
            begin
               s_next.cnt = s_reg.cnt + CNT_W'(1);
            end
            else if (!any_rst)
            begin
               s_next.seq = SEQ_WAIT_LOCK;
               s_next.pll_areset = 1'b0;
            end
         end
         SEQ_WAIT_LOCK:
         begin
            if (any_rst)
            begin
               s_next.seq = SEQ_PLL_RST;
               s_next.cnt = '0;
               s_next.pll_areset = 1'b1;
            end
            else if (lock_sync)
            begin
               s_next.seq = SEQ_RUN;
               s_next.sys_rst_n = 1'b1;
            end
         end
         SEQ_RUN:
         begin
            if (any_rst)
            begin
               s_next.seq = SEQ_PLL_RST;
               s_next.cnt = '0;
               s_next.pll_areset = 1'b1;
               s_next.sys_rst_n = 1'b0;
            end
         end
         default:
         begin
            s_next.seq = SEQ_PLL_RST;
            s_next.cnt = '0;
         end
      endcase

      // pin outputs; the macro runs its loop off clk as reference
      s_next.pll_ena = ENA_PRESENT ? pll_enable_in : 1'b1;
      s_next.pfd_ena = pfd_sel;
      s_next.lock = lock_sync;
      s_next.ext_ok = NEWER;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_reg.seq <= SEQ_PLL_RST;
         s_reg.cnt <= '0;
         s_reg.areset_bit <= CT_ARESET_RST;
         s_reg.pfd_bit <= CT_PFD_RST;
         s_reg.ph_cmd <= 2'h0;
         s_reg.pll_areset <= 1'b1;
         s_reg.sys_rst_n <= 1'b0;
         s_reg.pll_ena <= 1'b0;
         s_reg.pfd_ena <= CT_PFD_RST;
         s_reg.lock <= 1'b0;
         s_reg.ext_ok <= 1'b0;
         s_reg.phase <= '0;
         s_reg.rsp <= '0;
      end
      else if (ce)
      begin
         s_reg <= s_next;
      end
   end

   // always driven ports, whatever the access mode
   assign apb_rsp = s_reg.rsp;
   assign pll_areset_out = s_reg.pll_areset;
   assign pll_ena_out = s_reg.pll_ena;
   assign pfd_ena_out = s_reg.pfd_ena;
   assign phase_out = s_reg.phase;
   assign sys_rst_n_out = s_reg.sys_rst_n;
   assign lock_out = s_reg.lock;
   assign ext_clk_onchip_ok = s_reg.ext_ok;

   ////////////////////////////////////////////////////////////////////////////////

   a_cfg_reset_hold: assert property (@(posedge clk) disable iff (!rst_n)
      (s_reg.seq == SEQ_PLL_RST) |-> (pll_areset_out && !sys_rst_n_out))
      else $error("pll reset sequence not holding resets");

   a_release_lock: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(sys_rst_n_out) |-> $past(lock_sync))
      else $error("system reset released without lock");

   a_any_reset_sys: assert property (@(posedge clk) disable iff (!rst_n)
      (ce && any_rst) |=> (!sys_rst_n_out && pll_areset_out))
      else $error("pll reset did not reset the system");

   a_reset_min_len: assert property (@(posedge clk) disable iff (!rst_n)
      (ce && $rose(pll_areset_out)) |-> (s_reg.cnt == '0))
      else $error("pll reset pulse started without full count");

   a_pfd_from_bit: assert property (@(posedge clk) disable iff (!rst_n)
      (ce && PFD_REG) |=> (pfd_ena_out == $past(s_reg.pfd_bit)))
      else $error("detector enable does not follow control bit");

   a_status_ro: assert property (@(posedge clk) disable iff (!rst_n)
      (ce && wr && idx == IDX_STATUS) |=> ($stable(s_reg.areset_bit) && $stable(s_reg.pfd_bit)))
      else $error("status write changed control state");

   a_phase_step: assert property (@(posedge clk) disable iff (!rst_n)
      (ce && wr && mapped && NEWER && idx == IDX_PHASE
       && apb_req.pwdata[PH_CMD_LSB +: 2] == PH_CMD_UP)
      |=> (phase_out.up && !phase_out.down) ##1 (!phase_out.up || $past(wr)))
      else $error("phase step up not pulsed");

   a_apb_nowait: assert property (@(posedge clk) disable iff (!rst_n)
      (ce && setup) |=> (apb_rsp.pready && apb_req.penable))
      else $error("apb access phase did not complete at once");

   a_lock_follow: assert property (@(posedge clk) disable iff (!rst_n)
      ce |=> (lock_out == $past(lock_sync)))
      else $error("lock output does not follow synchronised lock");

endmodule

// ---- verification/pllw_pll_model.sv ----
// behavioural pll macro: lock after a settle time, phase done after steps
`timescale 1ns/10ps
module pllw_pll_model
   import pllw_pkg::*;
#(
   parameter int LOCK_CYC = 20
)
(
   // clock and controls
   input wire logic clk,
   input wire logic areset,
   input wire logic ena,
   input wire logic step,
   // status
   output logic locked_raw,
   output logic phase_done_raw
);
   int cnt;
   int busy;
   // lock only after settling with reset low and enable high
   always @(posedge clk or posedge areset)
   begin
      if (areset || !ena)
      begin
         cnt <= 0;
         locked_raw <= 1'b0;
      end
      else if (cnt < LOCK_CYC)
         cnt <= cnt + 1;
      else
         locked_raw <= 1'b1;
   end
   // a phase step keeps done low a few cycles
   always @(posedge clk)
   begin
      if (step)
         busy <= 4;
      else if (busy > 0)
         busy <= busy - 1;
   end
   assign phase_done_raw = locked_raw && (busy == 0);
endmodule

// ---- verification/testbench.sv ----
// self-checking bench of the pll wrapper control block
`timescale 1ns/10ps
module testbench
   import pllw_pkg::*;
;
   typedef struct packed {
      logic w;
      logic [3:0] a;
      logic [31:0] d;
      logic [31:0] exp;
      logic err;
   } pllw_row_s;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic reset_req_in = 1'b0;
   logic pll_enable_in = 1'b1;
   logic locked_raw;
   logic pdone_raw;
   logic areset;
   logic ena_out;
   logic pfd_out;
   logic sys_rst_n;
   logic lock_out;
   logic ext_ok;
   pllw_apb_req_s req = '0;
   pllw_apb_rsp_s rsp;
   pllw_phase_s ph;
   int num_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [31:0] rd;
   logic er;
   int n;
   int ups;
   int dns;
   pllw_row_s rows [8] = '{
      '{1'b0, 4'h4, 32'h0, 32'h2, 1'b0},
      '{1'b1, 4'h0, 32'h0, 32'h0, 1'b0},
      '{1'b0, 4'h0, 32'h0, 32'h3, 1'b0},
      '{1'b1, 4'h8, 32'h105, 32'h0, 1'b0},
      '{1'b0, 4'h8, 32'h0, 32'h105, 1'b0},
      '{1'b0, 4'hc, 32'h0, 32'h0, 1'b1},
      '{1'b0, 4'h2, 32'h0, 32'h0, 1'b1},
      '{1'b1, 4'h4, 32'hfffffffe, 32'h0, 1'b0}};

   always #4 clk = ~clk;

   pllw_ctrl pllw_ctrl_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .apb_req(req),
      .apb_rsp(rsp), .reset_req_in(reset_req_in), .pll_enable_in(pll_enable_in),
      .pfd_enable_in(1'b1), .pll_locked_raw(locked_raw), .pll_phase_done_raw(pdone_raw),
      .pll_areset_out(areset), .pll_ena_out(ena_out), .pfd_ena_out(pfd_out),
      .phase_out(ph), .sys_rst_n_out(sys_rst_n), .lock_out(lock_out),
      .ext_clk_onchip_ok(ext_ok));

   pllw_pll_model pllw_pll_model_inst (.clk(clk), .areset(areset), .ena(ena_out),
      .step(ph.up | ph.down), .locked_raw(locked_raw), .phase_done_raw(pdone_raw));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one apb transfer; waits counts access edges up to and including the one that sees pready
   task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int waits;
      waits = 0;
      @(posedge clk);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk);
      req.penable <= 1'b1;
      do
      begin
         @(posedge clk);
         waits++;
      end
      while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      er = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      chk("wait states", 1, waits);
   endtask

   // bounded wait for system reset release
   task automatic wait_sys();
      n = 0;
      while (sys_rst_n !== 1'b1 && n < 400)
      begin
         @(posedge clk);
         n++;
      end
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         num_errors++;
         report_and_stop();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      wait_sys();
      chk("ext clk ok", 1, ext_ok);
      for (int i = 0; i < 8; i++)
      begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         chk("slverr", rows[i].err, er);
         if (!rows[i].w)
            chk("rdata", rows[i].exp, rd);
      end
      $display("register rows done");
      // last row set every reserved bit; they must read back 0
      apb(1'b0, 4'h4, 0);
      chk("reserved read", 32'h2, rd);
      // detector enable follows only the control bit
      apb(1'b1, 4'h4, 0);
      repeat (2) @(posedge clk);
      chk("pfd off", 0, pfd_out);
      apb(1'b1, 4'h4, 32'h2);
      repeat (2) @(posedge clk);
      chk("pfd on", 1, pfd_out);
      $display("detector test done");
      // phase codes: only 01 and 10 pulse
      for (int c = 0; c < 4; c++)
      begin
         ups = 0;
         dns = 0;
         apb(1'b1, 4'h8, {c[1:0], 21'h0, 9'h100});
         repeat (4)
         begin
            @(posedge clk);
            ups += ph.up;
            dns += ph.down;
         end
         chk("step up", c == 1, ups);
         chk("step down", c == 2, dns);
         chk("sel", 9'h100, ph.sel);
      end
      $display("phase test done");
      // second configuration reset: pll held the full count
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      chk("cfg areset", 1, areset);
      chk("cfg sysrst", 0, sys_rst_n);
      chk("cfg status", 32'h0, rsp.prdata);
      rst_n <= 1'b1;
      n = 0;
      while (areset === 1'b1 && n < 300)
      begin
         @(posedge clk);
         n++;
      end
      // loop starts at the release edge, so it counts one edge past the hold
      chk("areset span", PLL_RST_CYC + 1, n);
      chk("held before lock", 0, sys_rst_n);
      wait_sys();
      chk("lock at release", 1, lock_out);
      $display("config reset test done");
      // register reset and pin reset both reset the system
      for (int k = 0; k < 2; k++)
      begin
         if (k == 0)
            apb(1'b1, 4'h4, 32'h3);
         else
            reset_req_in <= 1'b1;
         repeat (2) @(posedge clk);
         chk("req areset", 1, areset);
         chk("req sysrst", 0, sys_rst_n);
         if (k == 0)
            apb(1'b1, 4'h4, 32'h2);
         else
            reset_req_in <= 1'b0;
         wait_sys();
         chk("relocked", 1, sys_rst_n);
      end
      $display("reset request test done");
      // enable pin; lock loss is seen but does not reset the system
      pll_enable_in <= 1'b0;
      repeat (6) @(posedge clk);
      chk("ena out", 0, ena_out);
      chk("lock lost", 0, lock_out);
      chk("no sys reset", 1, sys_rst_n);
      apb(1'b0, 4'h0, 0);
      chk("status lock", 0, rd[ST_LOCK_BIT]);
      pll_enable_in <= 1'b1;
      repeat (30) @(posedge clk);
      chk("lock back", 1, lock_out);
      $display("enable test done");
      // clock enable low must freeze the registered enable pin
      ce <= 1'b0;
      pll_enable_in <= 1'b0;
      repeat (4) @(posedge clk);
      chk("ce freeze", 1, ena_out);
      ce <= 1'b1;
      pll_enable_in <= 1'b1;
      repeat (2) @(posedge clk);
      $display("clock enable test done");
      report_and_stop();
   end
endmodule
